// ### include/ref_clock_defs.vh
// Purpose: Constants for the reference clock divider setup block
// Assumes: Settings are 10 bits wide; higher bits of a load are dropped
// Notes: Two default sets chosen by the clock speed select strap
`ifndef REF_CLOCK_DEFS_VH
`define REF_CLOCK_DEFS_VH

`define SET_W 10
`define LOAD_W 16
`define SEL_W 3

// Setting selectors on the programming load port
`define SEL_GP_TIMER 3'h2
`define SEL_IDLE_DIV 3'h3
`define SEL_REF_DIV 3'h4
`define SEL_PLL_DIV 3'h5
`define SEL_ACT_DIV 3'h6
`define SEL_CONV_DIV 3'h7

// Defaults, fast reference
`define HI_GP_TIMER 10'h018
`define HI_IDLE_DIV 10'h088
`define HI_REF_DIV 10'h040
`define HI_PLL_DIV 10'h200

// Defaults, slow reference
`define LO_GP_TIMER 10'h017
`define LO_IDLE_DIV 10'h085
`define LO_REF_DIV 10'h024
`define LO_PLL_DIV 10'h1e0

// Defaults common to both references
`define ACT_DIV_DEF 10'h140
`define CONV_DIV_DEF 10'h008

// Operating modes
`define MODE_IDLE 2'h0
`define MODE_RX 2'h1
`define MODE_TX 2'h2

`endif

// ### core/reference_clock_divider_setup.v
// Purpose: Hold and apply the six clock divider settings
// Assumes: Loads arrive one cycle wide, synchronous to mclk_in
// Notes: Strap is caught each cycle of reset; loads only taken in idle
`include "ref_clock_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module reference_clock_divider_setup (
    input wire mclk_in, // 25 MHz clock
    input wire rst_in, // Synchronous reset, active high
    input wire clock_speed_select_in, // Strap, high = fast reference
    input wire [1:0] mode_in, // Operating mode idle/rx/tx
    input wire load_in, // Programming load strobe
    input wire [`SEL_W-1:0] load_sel_in, // Which setting is loaded
    input wire [`LOAD_W-1:0] load_data_in, // Loaded value
    output wire programming_ready_flag_out, // Ready to take a load
    output reg [`SET_W-1:0] gp_timer_out, // Active timer setting
    output reg [`SET_W-1:0] idle_div_out, // Active idle output divide
    output reg [`SET_W-1:0] ref_div_out, // Active reference divide
    output reg [`SET_W-1:0] pll_div_out, // Active PLL divide
    output reg [`SET_W-1:0] act_div_out, // Active mode output divide
    output reg [`SET_W-1:0] conv_div_out // Active converter divide
);

    ////////////////////////////////////////////////////////////////////////
    // Shadow settings waiting for their apply event
    reg [`SET_W-1:0] sh_gp_r;
    reg [`SET_W-1:0] sh_ref_r;
    reg [`SET_W-1:0] sh_pll_r;
    reg [`SET_W-1:0] sh_act_r;
    reg [`SET_W-1:0] sh_conv_r;
    reg [1:0] mode_r;

    // Next values
    reg [`SET_W-1:0] sh_gp_nxt;
    reg [`SET_W-1:0] sh_ref_nxt;
    reg [`SET_W-1:0] sh_pll_nxt;
    reg [`SET_W-1:0] sh_act_nxt;
    reg [`SET_W-1:0] sh_conv_nxt;
    reg [1:0] mode_nxt;
    reg [`SET_W-1:0] gp_timer_nxt;
    reg [`SET_W-1:0] idle_div_nxt;
    reg [`SET_W-1:0] ref_div_nxt;
    reg [`SET_W-1:0] pll_div_nxt;
    reg [`SET_W-1:0] act_div_nxt;
    reg [`SET_W-1:0] conv_div_nxt;

    wire idle_w;
    wire take_w;
    wire enter_w;
    wire [`SET_W-1:0] val_w;
    wire [`SET_W-1:0] def_gp_w;
    wire [`SET_W-1:0] def_idle_w;
    wire [`SET_W-1:0] def_ref_w;
    wire [`SET_W-1:0] def_pll_w;

    ////////////////////////////////////////////////////////////////////////
    // Load qualification
    assign idle_w = (mode_in == `MODE_IDLE);
    assign programming_ready_flag_out = idle_w & ~rst_in;
    assign take_w = load_in & programming_ready_flag_out;
    assign val_w = load_data_in[`SET_W-1:0];
    assign enter_w = (mode_in == `MODE_RX || mode_in == `MODE_TX) &&
                     (mode_r != mode_in);

    ////////////////////////////////////////////////////////////////////////
    // Strap dependent defaults
    // strap picks defaults
    assign def_gp_w = clock_speed_select_in ? `HI_GP_TIMER : `LO_GP_TIMER;
    assign def_idle_w = clock_speed_select_in ? `HI_IDLE_DIV : `LO_IDLE_DIV;
    assign def_ref_w = clock_speed_select_in ? `HI_REF_DIV : `LO_REF_DIV;
    assign def_pll_w = clock_speed_select_in ? `HI_PLL_DIV : `LO_PLL_DIV;

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always @*
    begin
        // Everything holds unless an event below moves it
        mode_nxt = mode_r;
        sh_gp_nxt = sh_gp_r;
        sh_ref_nxt = sh_ref_r;
        sh_pll_nxt = sh_pll_r;
        sh_act_nxt = sh_act_r;
        sh_conv_nxt = sh_conv_r;
        gp_timer_nxt = gp_timer_out;
        idle_div_nxt = idle_div_out;
        ref_div_nxt = ref_div_out;
        pll_div_nxt = pll_div_out;
        act_div_nxt = act_div_out;
        conv_div_nxt = conv_div_out;
        if (rst_in)
        begin
            // Idle after reset, so rx held through release applies once
            mode_nxt = `MODE_IDLE;
            gp_timer_nxt = def_gp_w;
            idle_div_nxt = def_idle_w;
            ref_div_nxt = def_ref_w;
            pll_div_nxt = def_pll_w;
            sh_gp_nxt = def_gp_w;
            sh_ref_nxt = def_ref_w;
            sh_pll_nxt = def_pll_w;
            act_div_nxt = `ACT_DIV_DEF;
            sh_act_nxt = `ACT_DIV_DEF;
            conv_div_nxt = `CONV_DIV_DEF;
            sh_conv_nxt = `CONV_DIV_DEF;
        end
        else
        begin
            mode_nxt = mode_in;
            if (take_w)
            begin
                case (load_sel_in)
                    `SEL_GP_TIMER:
                    begin
                        sh_gp_nxt = val_w;
                    end
                    `SEL_IDLE_DIV:
                    begin
                        gp_timer_nxt = sh_gp_r;
                        idle_div_nxt = val_w;
                    end
                    `SEL_REF_DIV:
                    begin
                        sh_ref_nxt = val_w;
                    end
                    `SEL_PLL_DIV:
                    begin
                        sh_pll_nxt = val_w;
                    end
                    `SEL_ACT_DIV:
                    begin
                        sh_act_nxt = val_w;
                    end
                    `SEL_CONV_DIV:
                    begin
                        sh_conv_nxt = val_w;
                    end
                    default:
                    begin
                        // Selectors without a setting are dropped
                        sh_gp_nxt = sh_gp_r;
                    end
                endcase
            end
            if (enter_w)
            begin
                ref_div_nxt = sh_ref_r;
                pll_div_nxt = sh_pll_r;
                act_div_nxt = sh_act_r;
                conv_div_nxt = sh_conv_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State and outputs
    always @(posedge mclk_in)
    begin
        mode_r <= mode_nxt;
        sh_gp_r <= sh_gp_nxt;
        sh_ref_r <= sh_ref_nxt;
        sh_pll_r <= sh_pll_nxt;
        sh_act_r <= sh_act_nxt;
        sh_conv_r <= sh_conv_nxt;
        gp_timer_out <= gp_timer_nxt;
        idle_div_out <= idle_div_nxt;
        ref_div_out <= ref_div_nxt;
        pll_div_out <= pll_div_nxt;
        act_div_out <= act_div_nxt;
        conv_div_out <= conv_div_nxt;
    end

endmodule // reference_clock_divider_setup

`default_nettype wire

// ### tb/rcd_asserts.sv
// Purpose: Port checks for the divider setup block
// Assumes: Bound to the block's top module
// Notes: Mode entry detection mirrors the previous-edge sample
`timescale 1ns/1ps
`default_nettype none
module rcd_asserts (
    input wire logic mclk_in, rst_in, clock_speed_select_in, load_in,
    input wire logic [1:0] mode_in,
    input wire logic [2:0] load_sel_in,
    input wire logic [15:0] load_data_in,
    input wire logic programming_ready_flag_out,
    input wire logic [9:0] gp_timer_out, idle_div_out, ref_div_out,
    input wire logic [9:0] pll_div_out, act_div_out, conv_div_out
);
default clocking @(posedge mclk_in); endclocking
default disable iff (rst_in);
wire idle_wr = load_in && mode_in == 2'h0;
wire [9:0] low_data = load_data_in[9:0];
a_ready_idle: assert property (programming_ready_flag_out == !mode_in)
    else $error("ready flag wrong");
a_idle_div_load: assert property (idle_wr &&
    load_sel_in == 3'h3 |=> idle_div_out == $past(low_data))
    else $error("idle divide not loaded");
a_timer_pair_load: assert property (idle_wr && load_sel_in == 3'h2 ##1
    idle_wr && load_sel_in == 3'h3 |=> gp_timer_out == $past(low_data, 2))
    else $error("timer not applied with idle divide");
a_pair_hold: assert property (!(idle_wr && load_sel_in == 3'h3) |=>
    $stable(gp_timer_out) && $stable(idle_div_out)) else $error("pair moved");
a_group_hold: assert property (!$past(rst_in) &&
    (mode_in == $past(mode_in) || mode_in == 2'h0 || mode_in == 2'h3) |=>
    $stable(ref_div_out) && $stable(pll_div_out) &&
    $stable(act_div_out) && $stable(conv_div_out))
    else $error("group moved without mode entry");
a_fast_defaults: assert property ($fell(rst_in) &&
    $past(clock_speed_select_in) |-> {gp_timer_out, idle_div_out,
    ref_div_out, pll_div_out} == {10'h018, 10'h088, 10'h040, 10'h200})
    else $error("fast defaults wrong");
a_slow_defaults: assert property ($fell(rst_in) &&
    !$past(clock_speed_select_in) |-> {gp_timer_out, idle_div_out,
    ref_div_out, pll_div_out} == {10'h017, 10'h085, 10'h024, 10'h1e0})
    else $error("slow defaults wrong");
a_common_defaults: assert property ($fell(rst_in) |->
    act_div_out == 10'h140 && conv_div_out == 10'h008)
    else $error("common defaults wrong");
endmodule // rcd_asserts
bind reference_clock_divider_setup rcd_asserts u_rcd_asserts (.mclk_in,
    .rst_in, .clock_speed_select_in, .load_in, .mode_in, .load_sel_in,
    .load_data_in, .programming_ready_flag_out, .gp_timer_out, .idle_div_out,
    .ref_div_out, .pll_div_out, .act_div_out, .conv_div_out);
`default_nettype wire

// ### tb/host_model.sv
// Purpose: Host side of the programming load
// Assumes: Load request comes from the bench
// Notes: Early loads after power-up stand
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic rdy_in, // Ready flag from the block
    input wire logic go_in, // Bench wants a load
    output logic ld_out // Load strobe
);
assign ld_out = go_in && rdy_in;
endmodule // host_model
`default_nettype wire

// ### tb/reference_clock_divider_setup_bench.sv
// Purpose: Self-checking bench for the divider setup block
// Assumes: Inputs change on the falling edge
// Notes: Power-up loads carry junk in bits 15:10
`timescale 1ns/1ps
`default_nettype none
module reference_clock_divider_setup_bench;
logic clk = 0, rst = 1, strap = 1, go = 0, raw = 0, rdy, ld;
logic [1:0] mode = 0;
logic [2:0] sel = 0;
logic [15:0] dat = 0;
logic [9:0] o[6];
int mismatches = 0, cmp_count = 0, cyc = 0;
logic [9:0] rv[6] = '{10'h3ff, 10'h10f, 10'h07d, 10'h300, 10'h2aa,
    10'h155};
logic [59:0] fd = {10'h018, 10'h088, 10'h040, 10'h200, 10'h140, 10'h008};
logic [59:0] sd = {10'h017, 10'h085, 10'h024, 10'h1e0, 10'h140, 10'h008};
always #20 clk = ~clk;
always @(posedge clk)
    if (++cyc > 2000)
    begin
        mismatches++;
        conclude;
    end
reference_clock_divider_setup u_reference_clock_divider_setup (
    .mclk_in(clk), .rst_in(rst), .clock_speed_select_in(strap),
    .mode_in(mode), .load_in(ld || raw), .load_sel_in(sel),
    .load_data_in(dat),
    .programming_ready_flag_out(rdy), .gp_timer_out(o[0]),
    .idle_div_out(o[1]), .ref_div_out(o[2]), .pll_div_out(o[3]),
    .act_div_out(o[4]), .conv_div_out(o[5]));
host_model u_host_model (.rdy_in(rdy), .go_in(go), .ld_out(ld));
task chk(input logic [9:0] g, e);
    cmp_count++;
    if (g !== e)
    begin
        mismatches++;
        $display("wrong value %0t got %h want %h", $time, g, e);
    end
endtask
task defs(input logic s, input logic [59:0] e);
    rst = 1;
    strap = s;
    repeat (8) @(negedge clk);
    chk({9'h0, rdy}, 10'h0);
    rst = 0;
    @(negedge clk);
    for (int i = 0; i < 6; i++)
        chk(o[i], e[59-10*i -: 10]);
endtask
task conclude;
    if (mismatches == 0 && cmp_count > 0)
        $display("No errors found");
    else
        $display("Errors were found");
    $finish;
endtask
initial begin
    defs(1'b0, sd);
    defs(1'b1, fd);
    // Loads right after power-up, each gated by the ready flag
    go = 1;
    for (int i = 0; i < 6; i++)
    begin
        sel = 3'(i + 2);
        dat = {6'h3f, rv[i]};
        @(negedge clk);
    end
    go = 0;
    for (int i = 0; i < 6; i++)
        chk(o[i], i < 2 ? rv[i] : fd[59-10*i -: 10]);
    mode = 1;
    @(negedge clk);
    for (int i = 0; i < 6; i++)
        chk(o[i], rv[i]);
    // Load pushed past the host gate while in tx must be dropped
    mode = 2;
    raw = 1;
    sel = 3;
    dat = 16'h0001;
    @(negedge clk);
    raw = 0;
    chk(o[1], rv[1]);
    chk({9'h0, rdy}, 10'h0);
    mode = 0;
    @(negedge clk);
    chk({9'h0, rdy}, 10'h1);
    go = 1;
    sel = 4;
    dat = 16'h0024;
    @(negedge clk);
    go = 0;
    mode = 3;
    @(negedge clk);
    chk(o[2], rv[2]);
    mode = 2;
    @(negedge clk);
    chk(o[2], 10'h024);
    conclude;
end
endmodule // reference_clock_divider_setup_bench
`default_nettype wire
